// [dim_host_model.sv]
// Host-side model counting alarms raised on the two flag pins
`timescale 1ns/1ps
module dim_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_crc_i,
  input wire logic pin_pc_i,
  output logic [7:0] crc_alerts_o,
  output logic [7:0] pc_alerts_o
);
  logic crc_q;
  logic pc_q;
  // Edge counting: a held flag is one interrupt, not one per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_q <= 1'b0;
      pc_q <= 1'b0;
      crc_alerts_o <= 8'h00;
      pc_alerts_o <= 8'h00;
    end else begin
      crc_q <= pin_crc_i;
      pc_q <= pin_pc_i;
      crc_alerts_o <= crc_alerts_o + {7'h00, pin_crc_i && !crc_q};
      pc_alerts_o <= pc_alerts_o + {7'h00, pin_pc_i && !pc_q};
    end
  end
endmodule

// [dim_monitor.sv]
// Integrity monitor: program-memory CRC, program-counter watchdog, peak counter, mute
`timescale 1ns/1ps
module dim_monitor
  import dim_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core side, same clock
  input wire logic frame_start_i,
  input wire logic jump_to_start_i,
  input wire dim_prog_wr_t prog_wr_i,
  input wire logic [23:0] audio_i,
  output logic [23:0] audio_o,
  output logic [15:0] pc_o,
  output logic frame_overrun_o,
  output logic core_mute_o,
  // Multipurpose pins
  input wire logic mp_sel_crc_i,
  input wire logic mp_sel_pc_i,
  output logic multipurpose_pin_crc_o,
  output logic multipurpose_pin_pc_o,
  output dim_status_t status_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] crc_reference_high;
  logic [15:0] crc_reference_low;
  logic crc_check_enable;
  logic pc_limit_enable;
  logic [15:0] pc_limit_high;
  logic [15:0] pc_limit_low;
  logic crc_fault_flag;
  logic pc_limit_fault_flag;
  logic [1:0] fault_auto_mute;
  logic core_run;
  logic [1:0] core_rate;
  logic [15:0] peak_cycle_count;

  logic [OPCODE_W-1:0] prog_mem [PROG_DEPTH];

  logic [15:0] reg_idx;
  logic bus_req;
  logic bus_wr;
  logic [31:0] next_rdata;
  logic [15:0] wr_word;

  assign reg_idx = wb_adr_i[ADDR_W-1:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign wr_word = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

  // Merge byte lanes with the stored value
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [1:0] sel,
                                             input logic [15:0] new_v);
    lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // One CRC-32 step over a single bit, MSB first
  function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
    crc_bit = (c[31] ^ b) ? ({c[30:0], 1'b0} ^ CRC_POLY) : {c[30:0], 1'b0};
  endfunction

  // Whole opcode, zero-padded bits included
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [OPCODE_W-1:0] w);
    logic [31:0] acc;
    acc = c;
    for (int i = OPCODE_W - 1; i >= 0; i--) begin
      acc = crc_bit(acc, w[i]);
    end
    crc_word = acc;
  endfunction

  // ---------------------------------------------------------------
  // Wishbone slave: one wait-free cycle, ack the cycle after stb
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_idx == REG_CRC_REFERENCE_HIGH) begin
      next_rdata[15:0] = crc_reference_high;
    end else if (reg_idx == REG_CRC_REFERENCE_LOW) begin
      next_rdata[15:0] = crc_reference_low;
    end else if (reg_idx == REG_CRC_CHECK_ENABLE) begin
      next_rdata[ENABLE_BIT] = crc_check_enable;
    end else if (reg_idx == REG_PC_LIMIT_ENABLE) begin
      next_rdata[ENABLE_BIT] = pc_limit_enable;
    end else if (reg_idx == REG_PC_LIMIT_HIGH) begin
      next_rdata[15:0] = pc_limit_high;
    end else if (reg_idx == REG_PC_LIMIT_LOW) begin
      next_rdata[15:0] = pc_limit_low;
    end else if (reg_idx == REG_CRC_FAULT_FLAG) begin
      next_rdata[ENABLE_BIT] = crc_fault_flag;
    end else if (reg_idx == REG_PC_LIMIT_FAULT_FLAG) begin
      next_rdata[ENABLE_BIT] = pc_limit_fault_flag;
    end else if (reg_idx == REG_FAULT_AUTO_MUTE) begin
      next_rdata[1:0] = fault_auto_mute;
    end else if (reg_idx == REG_CORE_RUN) begin
      next_rdata[ENABLE_BIT] = core_run;
    end else if (reg_idx == REG_PEAK_CYCLE_COUNT) begin
      next_rdata[15:0] = peak_cycle_count;
    end else if (reg_idx == REG_CORE_RATE) begin
      next_rdata[1:0] = core_rate;
    end else if (reg_idx[15:12] == PROG_BASE[15:12]) begin
      // Program memory reads return opcode low 32 bits
      next_rdata = prog_mem[reg_idx[PROG_AW-1:0]][31:0];
    end else begin
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Writable control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_reference_high <= REG_RESET;
      crc_reference_low <= REG_RESET;
      crc_check_enable <= 1'b0;
    end else if (bus_wr) begin
      if (reg_idx == REG_CRC_REFERENCE_HIGH) begin
        crc_reference_high <= lane_merge(crc_reference_high, wb_sel_i[1:0], wb_dat_i[15:0]);
      end else if (reg_idx == REG_CRC_REFERENCE_LOW) begin
        crc_reference_low <= lane_merge(crc_reference_low, wb_sel_i[1:0], wb_dat_i[15:0]);
      end else if (reg_idx == REG_CRC_CHECK_ENABLE && wb_sel_i[0]) begin
        crc_check_enable <= wb_dat_i[ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_limit_enable <= 1'b0;
      pc_limit_high <= REG_RESET;
      pc_limit_low <= REG_RESET;
    end else if (bus_wr) begin
      if (reg_idx == REG_PC_LIMIT_ENABLE && wb_sel_i[0]) begin
        pc_limit_enable <= wb_dat_i[ENABLE_BIT];
      end else if (reg_idx == REG_PC_LIMIT_HIGH) begin
        pc_limit_high <= lane_merge(pc_limit_high, wb_sel_i[1:0], wb_dat_i[15:0]);
      end else if (reg_idx == REG_PC_LIMIT_LOW) begin
        pc_limit_low <= lane_merge(pc_limit_low, wb_sel_i[1:0], wb_dat_i[15:0]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_auto_mute <= 2'h0;
      core_run <= 1'b0;
      core_rate <= DIM_RATE_NORMAL;
    end else if (bus_wr && wb_sel_i[0]) begin
      if (reg_idx == REG_FAULT_AUTO_MUTE) begin
        fault_auto_mute <= wb_dat_i[1:0];
      end else if (reg_idx == REG_CORE_RUN) begin
        core_run <= wb_dat_i[ENABLE_BIT];
      end else if (reg_idx == REG_CORE_RATE) begin
        core_rate <= wb_dat_i[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Program memory: 43-bit opcodes at word 0x2000
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (bus_wr && reg_idx[15:12] == PROG_BASE[15:12]) begin
      // Bus writes fill low 32 bits with halves swapped and clear the top 11; core port carries whole opcode
      prog_mem[reg_idx[PROG_AW-1:0]] <= {11'h000, wr_word, wb_dat_i[31:16]};
    end else if (prog_wr_i.we) begin
      prog_mem[prog_wr_i.addr] <= prog_wr_i.data;
    end
  end

  // ---------------------------------------------------------------
  // CRC scan: frame count, then sweep whole memory, one word a cycle
  // ---------------------------------------------------------------
  dim_crc_state_t crc_state;
  logic [12:0] frame_cnt;
  logic [PROG_AW-1:0] scan_addr;
  logic [31:0] crc_acc;

  always_ff @(posedge clk_i) begin
    if (rst_i || !crc_check_enable) begin
      crc_state <= DIM_CRC_IDLE;
      frame_cnt <= 13'h0000;
      scan_addr <= '0;
      crc_acc <= CRC_SEED;
    end else begin
      if (frame_start_i) begin
        frame_cnt <= (frame_cnt == CRC_PERIOD_FRAMES - 13'h0001) ? 13'h0000
                     : frame_cnt + 13'h0001;
      end
      case (crc_state)
        DIM_CRC_IDLE: begin
          if (frame_start_i && frame_cnt == CRC_PERIOD_FRAMES - 13'h0001) begin
            crc_state <= DIM_CRC_SCAN;
            scan_addr <= '0;
            crc_acc <= CRC_SEED;
          end
        end
        DIM_CRC_SCAN: begin
          crc_acc <= crc_word(crc_acc, prog_mem[scan_addr]);
          scan_addr <= scan_addr + 1'b1;
          if (&scan_addr) begin
            crc_state <= DIM_CRC_CMP;
          end
        end
        DIM_CRC_CMP: begin
          crc_state <= DIM_CRC_IDLE;
        end
        default: begin
          crc_state <= DIM_CRC_IDLE;
        end
      endcase
    end
  end

  // Sticky: cleared only by reset or enable low, so no clear race exists
  always_ff @(posedge clk_i) begin
    if (rst_i || !crc_check_enable) begin
      crc_fault_flag <= 1'b0;
    end else if (crc_state == DIM_CRC_CMP &&
                 crc_acc != {crc_reference_high, crc_reference_low}) begin
      crc_fault_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Program counter, instruction budget and watchdog
  // ---------------------------------------------------------------
  logic [15:0] pc;
  logic pc_running;
  logic [31:0] pc_cycles;
  logic [15:0] cycle_cnt;
  logic [11:0] instr_cnt;
  logic [11:0] instr_max;

  always_comb begin
    case (core_rate)
      DIM_RATE_DUAL: instr_max = MAX_INSTR_DUAL;
      DIM_RATE_QUAD: instr_max = MAX_INSTR_QUAD;
      default: instr_max = MAX_INSTR_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !core_run) begin
      pc <= PC_START;
      pc_running <= 1'b0;
      instr_cnt <= 12'h000;
    end else if (frame_start_i) begin
      pc <= PC_START;
      pc_running <= 1'b1;
      instr_cnt <= 12'h000;
    end else if (pc_running) begin
      if (jump_to_start_i || instr_cnt == instr_max - 12'h001) begin
        pc <= PC_START;
        pc_running <= 1'b0;
      end else begin
        pc <= {PROG_BASE[15:12], pc[PROG_AW-1:0] + 12'h001};
        instr_cnt <= instr_cnt + 12'h001;
      end
    end
  end

  // Counts since program start; keeps counting if the PC never returns
  always_ff @(posedge clk_i) begin
    if (rst_i || !core_run) begin
      pc_cycles <= 32'h00000000;
      cycle_cnt <= 16'h0000;
      peak_cycle_count <= 16'h0000;
      frame_overrun_o <= 1'b0;
    end else if (frame_start_i) begin
      peak_cycle_count <= cycle_cnt;
      frame_overrun_o <= pc_running;
      pc_cycles <= 32'h00000000;
      cycle_cnt <= 16'h0000;
    end else begin
      pc_cycles <= pc_cycles + 32'h00000001;
      if (pc_running) begin
        cycle_cnt <= cycle_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !pc_limit_enable) begin
      pc_limit_fault_flag <= 1'b0;
    end else if (core_run && pc_cycles == {pc_limit_high, pc_limit_low}) begin
      pc_limit_fault_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Mute, audio and pins
  // ---------------------------------------------------------------
  logic mute;
  assign mute = (crc_fault_flag && fault_auto_mute[MUTE_CRC_BIT]) ||
                (pc_limit_fault_flag && fault_auto_mute[MUTE_PC_BIT]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      audio_o <= 24'h000000;
    end else begin
      audio_o <= (core_run && !mute) ? audio_i : 24'h000000;
    end
  end

  always_comb begin
    core_mute_o = mute || !core_run;
    pc_o = pc;
    multipurpose_pin_crc_o = mp_sel_crc_i && crc_fault_flag;
    multipurpose_pin_pc_o = mp_sel_pc_i && pc_limit_fault_flag;
    status_o = '{crc_fault: crc_fault_flag, pc_fault: pc_limit_fault_flag, mute: mute};
  end

endmodule

// [dim_monitor_sva.sv]
// Concurrent checks on the integrity monitor ports
`timescale 1ns/1ps
module dim_monitor_sva
  import dim_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic frame_start_i,
  input wire logic jump_to_start_i,
  input wire dim_prog_wr_t prog_wr_i,
  input wire logic [23:0] audio_i,
  input wire logic [23:0] audio_o,
  input wire logic [15:0] pc_o,
  input wire logic frame_overrun_o,
  input wire logic core_mute_o,
  input wire logic mp_sel_crc_i,
  input wire logic mp_sel_pc_i,
  input wire logic multipurpose_pin_crc_o,
  input wire logic multipurpose_pin_pc_o,
  input wire dim_status_t status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic take;
  logic clr_crc;
  logic clr_pc;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr_crc = take && wb_we_i && wb_adr_i[17:2] == REG_CRC_CHECK_ENABLE && !wb_dat_i[0];
  assign clr_pc = take && wb_we_i && wb_adr_i[17:2] == REG_PC_LIMIT_ENABLE && !wb_dat_i[0];
  sequence taken_s;
    take;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  bus_answer_a: assert property (taken_s |=> ack_pulse_s)
    else $error("bus request not answered by a single ack");
  crc_pin_route_a: assert property (
    multipurpose_pin_crc_o == (mp_sel_crc_i && status_o.crc_fault))
    else $error("crc pin does not follow select and flag");
  pc_pin_route_a: assert property (
    multipurpose_pin_pc_o == (mp_sel_pc_i && status_o.pc_fault))
    else $error("watchdog pin does not follow select and flag");
  crc_flag_hold_a: assert property (
    status_o.crc_fault && !clr_crc && !$past(clr_crc) |=> status_o.crc_fault)
    else $error("crc flag dropped without enable cleared");
  crc_flag_clear_a: assert property (clr_crc |-> ##2 !status_o.crc_fault)
    else $error("crc flag stays after enable cleared");
  pc_flag_hold_a: assert property (
    status_o.pc_fault && !clr_pc && !$past(clr_pc) |=> status_o.pc_fault)
    else $error("watchdog flag dropped without enable cleared");
  pc_flag_clear_a: assert property (clr_pc |-> ##2 !status_o.pc_fault)
    else $error("watchdog flag stays after enable cleared");
  mute_follow_a: assert property (status_o.mute |-> core_mute_o)
    else $error("mute status without core mute");
  audio_silent_a: assert property (core_mute_o |=> audio_o == 24'h000000)
    else $error("audio not silent while muted or halted");
  pc_restart_a: assert property (frame_start_i |=> pc_o == PC_START)
    else $error("program counter not at start after frame pulse");
endmodule
bind dim_monitor dim_monitor_sva u_dim_sva (.*);

// [dim_pkg.sv]
// Package of register map, field layout and timing constants for the integrity monitor
package dim_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_CRC_REFERENCE_HIGH = 16'hE200;
  localparam logic [15:0] REG_CRC_REFERENCE_LOW = 16'hE201;
  localparam logic [15:0] REG_CRC_CHECK_ENABLE = 16'hE202;
  localparam logic [15:0] REG_PC_LIMIT_ENABLE = 16'hE210;
  localparam logic [15:0] REG_PC_LIMIT_HIGH = 16'hE211;
  localparam logic [15:0] REG_PC_LIMIT_LOW = 16'hE212;
  localparam logic [15:0] REG_CRC_FAULT_FLAG = 16'hE225;
  localparam logic [15:0] REG_PC_LIMIT_FAULT_FLAG = 16'hE226;
  localparam logic [15:0] REG_FAULT_AUTO_MUTE = 16'hE227;
  localparam logic [15:0] REG_CORE_RUN = 16'hE228;
  localparam logic [15:0] REG_PEAK_CYCLE_COUNT = 16'hE229;
  localparam logic [15:0] REG_CORE_RATE = 16'hE230;
  localparam int ADDR_W = 18;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int MUTE_PC_BIT = 0;
  localparam int MUTE_CRC_BIT = 1;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

  // ---------------------------------------------------------------
  // Program memory and program counter
  // ---------------------------------------------------------------
  localparam int OPCODE_W = 43;
  localparam int PROG_DEPTH = 4096;
  localparam int PROG_AW = 12;
  localparam logic [15:0] PROG_BASE = 16'h2000;
  localparam logic [15:0] PC_START = 16'h2010;
  localparam logic [11:0] PC_START_OFS = 12'h010;
  localparam logic [12:0] CRC_PERIOD_FRAMES = 13'h1000;
  localparam logic [11:0] MAX_INSTR_NORMAL = 12'hE00;
  localparam logic [11:0] MAX_INSTR_DUAL = 12'h700;
  localparam logic [11:0] MAX_INSTR_QUAD = 12'h380;

  typedef enum logic [1:0] {
    DIM_RATE_NORMAL = 2'h0,
    DIM_RATE_DUAL = 2'h1,
    DIM_RATE_QUAD = 2'h2
  } dim_rate_t;

  typedef enum logic [1:0] {
    DIM_CRC_IDLE = 2'b00,
    DIM_CRC_SCAN = 2'b01,
    DIM_CRC_CMP = 2'b11
  } dim_crc_state_t;

  // Core program-memory write port from the control path
  typedef struct packed {
    logic we;
    logic [PROG_AW-1:0] addr;
    logic [OPCODE_W-1:0] data;
  } dim_prog_wr_t;

  // Status driven out on status_o; the pins carry only the selected fault flags, never mute
  typedef struct packed {
    logic crc_fault;
    logic pc_fault;
    logic mute;
  } dim_status_t;

endpackage

// [tb_dim_monitor.sv]
// Self-checking bench for the integrity monitor with a pin-watching host
`timescale 1ns/1ps
module tb_dim_monitor;
  import dim_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, fs = 1'b0, jmp = 1'b0;
  logic sel_crc = 1'b0, sel_pc = 1'b0, ovr, mute, pin_crc, pin_pc;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] dat = '0, rdat, crc, v;
  logic [23:0] ain = '0, aout;
  logic [15:0] pc;
  logic [7:0] crc_alerts, pc_alerts;
  logic [42:0] mem [PROG_DEPTH];
  logic [31:0] q [$];
  logic [15:0] regs [10] = '{REG_CRC_REFERENCE_HIGH, REG_CRC_REFERENCE_LOW, REG_CRC_CHECK_ENABLE,
    REG_PC_LIMIT_ENABLE, REG_PC_LIMIT_HIGH, REG_PC_LIMIT_LOW, REG_CRC_FAULT_FLAG,
    REG_PC_LIMIT_FAULT_FLAG, REG_FAULT_AUTO_MUTE, 16'hE2FF};
  dim_prog_wr_t prog = '0;
  dim_status_t st;
  int n_errors = 0, n_tests = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  dim_monitor uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_start_i(fs), .jump_to_start_i(jmp), .prog_wr_i(prog), .audio_i(ain), .audio_o(aout),
    .pc_o(pc), .frame_overrun_o(ovr), .core_mute_o(mute), .mp_sel_crc_i(sel_crc),
    .mp_sel_pc_i(sel_pc), .multipurpose_pin_crc_o(pin_crc), .multipurpose_pin_pc_o(pin_pc),
    .status_o(st));
  dim_host_model host (.clk_i(clk_i), .rst_i(rst_i), .pin_crc_i(pin_crc), .pin_pc_i(pin_pc),
    .crc_alerts_o(crc_alerts), .pc_alerts_o(pc_alerts));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    q.push_back(exp);
    bus(1'b0, idx, 32'h0);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_i);
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
    end
  endtask
  // Values are taken 1 ns past the edge: an argument would be frozen at the call
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask
  // ---------------------------------------------------------------
  // Read-data watcher and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) check(rdat, q.pop_front());
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(91120));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rd(regs[i], 32'h0);
    foreach (regs[i]) begin
      if (i inside {2, 3, 8}) continue;
      v = $urandom;
      bus(1'b1, regs[i], v);
      rd(regs[i], (i < 6) ? {16'h0, v[15:0]} : 32'h0);
    end
    ain <= 24'($urandom);
    bus(1'b1, REG_CORE_RUN, 32'h1);
    sel_pc <= 1'b1;
    settle();
    check({31'h0, aout === ain}, 32'h1);
    bus(1'b1, REG_PC_LIMIT_HIGH, 32'h0);
    bus(1'b1, REG_PC_LIMIT_LOW, 32'h28);
    bus(1'b1, REG_FAULT_AUTO_MUTE, 32'h1);
    bus(1'b1, REG_PC_LIMIT_ENABLE, 32'h1);
    frames(1);
    jmp <= 1'b1;
    @(posedge clk_i);
    jmp <= 1'b0;
    repeat (26) @(posedge clk_i);
    settle();
    check({31'h0, pin_pc}, 32'h0);
    repeat (16) @(posedge clk_i);
    settle();
    check({31'h0, pin_pc}, 32'h1);
    settle();
    check({31'h0, mute}, 32'h1);
    check({29'h0, st}, 32'h3);
    settle();
    check({31'h0, aout == 24'h0}, 32'h1);
    @(posedge clk_i);
    sel_pc <= 1'b0;
    settle();
    check({31'h0, pin_pc}, 32'h0);
    rd(REG_PC_LIMIT_FAULT_FLAG, 32'h1);
    bus(1'b1, REG_FAULT_AUTO_MUTE, 32'h0);
    settle();
    check({31'h0, mute}, 32'h0);
    bus(1'b1, REG_PC_LIMIT_ENABLE, 32'h0);
    rd(REG_PC_LIMIT_FAULT_FLAG, 32'h0);
    // Peak count: program runs ten cycles from its start to the jump
    frames(1);
    repeat (9) @(posedge clk_i);
    jmp <= 1'b1;
    @(posedge clk_i);
    jmp <= 1'b0;
    settle();
    check({16'h0, pc}, {16'h0, PC_START});
    frames(1);
    rd(REG_PEAK_CYCLE_COUNT, 32'h0000000A);
    settle();
    check({31'h0, ovr}, 32'h0);
    for (int i = 0; i < PROG_DEPTH; i++) begin
      @(posedge clk_i);
      mem[i] = {11'($urandom), 32'($urandom)};
      prog <= '{we: 1'b1, addr: 12'(i), data: mem[i]};
    end
    @(posedge clk_i);
    prog <= '0;
    crc = CRC_SEED;
    foreach (mem[w]) begin
      for (int b = OPCODE_W - 1; b >= 0; b--) begin
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ mem[w][b]) ? CRC_POLY : 32'h0);
      end
    end
    // Reference off by one bit: the nearest miss must still be caught
    bus(1'b1, REG_CRC_REFERENCE_HIGH, {16'h0, crc[31:16]});
    bus(1'b1, REG_CRC_REFERENCE_LOW, {16'h0, crc[15:0] ^ 16'h0001});
    sel_crc <= 1'b1;
    bus(1'b1, REG_FAULT_AUTO_MUTE, 32'h2);
    bus(1'b1, REG_CRC_CHECK_ENABLE, 32'h1);
    frames(4095);
    // Frames two cycles apart never let the program return
    settle();
    check({31'h0, ovr}, 32'h1);
    repeat (4100) @(posedge clk_i);
    rd(REG_CRC_FAULT_FLAG, 32'h0);
    frames(1);
    repeat (4100) @(posedge clk_i);
    rd(REG_CRC_FAULT_FLAG, 32'h1);
    settle();
    check({31'h0, pin_crc}, 32'h1);
    check({31'h0, mute}, 32'h1);
    check({29'h0, st}, 32'h5);
    check({24'h0, crc_alerts}, 32'h1);
    check({24'h0, pc_alerts}, 32'h1);
    bus(1'b1, REG_CRC_CHECK_ENABLE, 32'h0);
    rd(REG_CRC_FAULT_FLAG, 32'h0);
    bus(1'b1, REG_CRC_REFERENCE_LOW, {16'h0, crc[15:0]});
    bus(1'b1, REG_CRC_CHECK_ENABLE, 32'h1);
    frames(4096);
    repeat (4100) @(posedge clk_i);
    rd(REG_CRC_FAULT_FLAG, 32'h0);
    settle();
    check({31'h0, mute}, 32'h0);
    bus(1'b1, REG_CORE_RUN, 32'h0);
    settle();
    check({31'h0, aout == 24'h0}, 32'h1);
    repeat (3) @(posedge clk_i);
    print_verdict();
  end
endmodule
